// ==== logic/bfpm_pkg.sv ====
/*
  Shared constants for the buck fault protection manager: register
  addresses, field positions, reset values, fault thresholds, timing
  figures, link frame layout and state encodings.
  Assumes both ends of the two-wire link compile against this package.
*/
`default_nettype none

package bfpm_pkg;

  // ==========================================================
  // Register addresses (low six bits of the command)
  localparam logic [5:0] REG_MAIN_CTRL = 6'h00;
  localparam logic [5:0] REG_OUT_CTRL = 6'h01;
  localparam logic [5:0] REG_VOUT = 6'h02;
  localparam logic [5:0] REG_FAULT = 6'h03;

  // ==========================================================
  // Field positions
  localparam int FLT_WARN = 7;
  localparam int FLT_EN = 6;
  localparam int FLT_CFG_ERR = 5;
  localparam int FLT_SETTLED = 4;
  localparam int FLT_RETRY = 3;
  localparam int FLT_OT = 2;
  localparam int FLT_LATCH = 1;
  localparam int FLT_INREG = 0;
  localparam int OC_FULL_DUTY = 7;
  localparam int OC_FORCED = 6;
  localparam int OC_RESTART_SEL = 5;
  localparam int OC_DISCHARGE = 4;
  localparam int OC_RAMP_MSB = 3;
  localparam int MC_TON_MSB = 7;
  localparam int MC_TON_LSB = 6;
  localparam int MC_HIGH_SIDE_CURRENT_LIMIT_SEL_MSB = 5;
  localparam int MC_HIGH_SIDE_CURRENT_LIMIT_SEL_LSB = 4;
  localparam int MC_SW_EN = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] OUT_CTRL_RST = 8'h20;
  localparam logic [7:0] VOUT_RST = 8'h00;

  // ==========================================================
  // Fault thresholds
  localparam logic [2:0] THERM_LATCH_CNT = 3'h4;
  localparam logic [2:0] HICCUP_LATCH_CNT = 3'h4;
  localparam logic [3:0] OVERLOAD_CYC = 4'h7;
  localparam logic [3:0] PREBIAS_CYC = 4'h8;

  // ==========================================================
  // Timing
  localparam int SYS_CLK_MHZ = 125;
  localparam int SYS_PERIOD_NS = 8;
  localparam int COOL_OFF_MS = 1;
  localparam int COOL_OFF_CYC = COOL_OFF_MS * 1000 * SYS_CLK_MHZ;
  localparam int PG_BLANK_US = 65;
  localparam int PG_BLANK_CYC = PG_BLANK_US * SYS_CLK_MHZ;
  localparam int LINK_PERIOD_NS = 32;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);

  // ==========================================================
  // Link frame bit indices (bit 0 is the start bit)
  localparam logic [4:0] FRM_RW = 5'h01;
  localparam logic [4:0] FRM_ADDR_LAST = 5'h07;
  localparam logic [4:0] FRM_TURN_LAST = 5'h0b;
  localparam logic [4:0] FRM_RD_FIRST = 5'h0c;
  localparam logic [4:0] FRM_WR_LAST = 5'h0f;
  localparam logic [4:0] FRM_RD_LAST = 5'h13;

  // ==========================================================
  // State encodings
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_RUN = 5'h02,
    ST_THERM = 5'h04,
    ST_HICCUP = 5'h08,
    ST_LATCH = 5'h10
  } bfpm_state_type;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_LOW = 3'h2,
    HS_HIGH = 3'h4
  } bfpm_host_state_type;

endpackage

`default_nettype wire

// ==== logic/bfpm_link_if.sv ====
/*
  Two-wire link between host and regulator: clock driven by the host,
  open-drain data resolved here from both enables.
  Assumes a pull-up: the data line is high unless someone pulls it low.
*/
`timescale 1ns/1ns
`default_nettype none

interface bfpm_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire logic sda;

  // Wired-AND of both drivers over the pull-up
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

`default_nettype wire

// ==== logic/bfpm_device.sv ====
/*
  Regulator-side fault and protection manager with its register file and
  the link slave. Link logic runs on the link clock, fault logic on clk_sys.
  Assumes comparator inputs are asynchronous levels and loop_cycle_tgl
  toggles once per commanded switching cycle.
*/
// Overview of operation
// - Warning flag follows temperature above warning threshold
// - Shutdown turns both switches off until cool
// - Shutdown sets fault flag, clears warning flag
// - Restart mode: settled low, retry high
// - Fault clears in-regulation bit and power-good
// - Link and registers keep working during faults
// - Fault flag sticky; host writes zero clears
// - Four shutdowns before power-good cause latch-off
// - Latch-off left by enable toggle or power
// - Restart select zero latches on first shutdown
// - Eight cycles before forced switching, negative limit
// - Start-up counter cleared on disable or fault
// - Current limit forces low side until 80%
// - Over seven limited cycles start hiccup cool-off
// - Fourth hiccup before power-good latches off
// - Hiccup sets retry, clears settled and power-good
// - Two-bit field selects high-side current limit
// - Registers keep values across enable, reset only
// - Settings written while disabled used at start
// - Lower voltage forces switching, blanks power-good
// - Status register bit order at address three
// - Output control register bit order at one
`timescale 1ns/1ns
`default_nettype none

module bfpm_device #(
  parameter int COOL_CYC = bfpm_pkg::COOL_OFF_CYC,
  parameter int BLANK_CYC = bfpm_pkg::PG_BLANK_CYC,
  parameter logic [7:0] MAIN_RST = bfpm_pkg::MAIN_CTRL_RST,
  parameter logic [7:0] OUT_RST = bfpm_pkg::OUT_CTRL_RST,
  parameter logic [7:0] VOUT_INIT = bfpm_pkg::VOUT_RST
) (
  input wire logic clk_sys,
  input wire logic rst,
  bfpm_link_if.dev link,
  input wire logic en_pin,
  input wire logic input_low_lockout,
  input wire logic temp_warn_cmp,
  input wire logic temp_shut_cmp,
  input wire logic temp_cool_cmp,
  input wire logic hs_limit_cmp,
  input wire logic hs_below80_cmp,
  input wire logic loop_cycle_tgl,
  input wire logic pg_cmp,
  output logic switches_off,
  output logic hs_gate_allow,
  output logic ls_force_on,
  output logic neg_limit_en,
  output logic forced_fixed_switching,
  output logic output_discharge_enable,
  output logic full_duty_disable,
  output logic [1:0] high_side_current_limit_sel,
  output logic [1:0] on_time_select,
  output logic [3:0] ramp_rate,
  output logic [7:0] vout_code,
  output logic pg_pin_o,
  output logic pg_pin_oe
);
  localparam int CW = $clog2(COOL_CYC + 1);
  localparam int BW = $clog2(BLANK_CYC + 1);

  // ==========================================================
  // Link side (link clock)
  logic [4:0] bit_q;
  logic rw_q;
  logic [5:0] addr_q;
  logic [7:0] sh_q;
  logic wr_tgl_q;
  logic rd_tgl_q;
  logic ack_meta_q;
  logic ack_sync_q;
  logic rd_ack_q;
  logic [7:0] rd_word_q;

  // Serial frame: start, rw, address, then write data or read data
  always_ff @(posedge link.scl or posedge rst)
  begin
    if (rst)
    begin
      bit_q <= 5'h00;
      rw_q <= 1'b0;
      addr_q <= 6'h00;
      sh_q <= 8'h00;
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
      link.dev_sda_oe <= 1'b0;
    end
    else if (bit_q == 5'h00)
    begin
      if (!link.sda)
        bit_q <= bfpm_pkg::FRM_RW;
    end
    else
    begin
      bit_q <= bit_q + 5'h01;
      if (bit_q == bfpm_pkg::FRM_RW)
        rw_q <= link.sda;
      else if (bit_q <= bfpm_pkg::FRM_ADDR_LAST)
        addr_q <= {addr_q[4:0], link.sda};
      if (bit_q == bfpm_pkg::FRM_ADDR_LAST && rw_q)
        rd_tgl_q <= ~rd_tgl_q;
      if (!rw_q && bit_q > bfpm_pkg::FRM_ADDR_LAST)
      begin
        sh_q <= {sh_q[6:0], link.sda};
        if (bit_q == bfpm_pkg::FRM_WR_LAST)
        begin
          wr_tgl_q <= ~wr_tgl_q;
          bit_q <= 5'h00;
        end
      end
      else if (rw_q && bit_q == bfpm_pkg::FRM_TURN_LAST)
      begin
        // A word not yet handed over reads as zero rather than stale
        sh_q <= (ack_sync_q == rd_tgl_q) ? rd_word_q : 8'h00;
        link.dev_sda_oe <= (ack_sync_q == rd_tgl_q) ? ~rd_word_q[7] : 1'b1;
      end
      else if (rw_q && bit_q >= bfpm_pkg::FRM_RD_FIRST)
      begin
        sh_q <= {sh_q[6:0], 1'b0};
        link.dev_sda_oe <= ~sh_q[6];
        if (bit_q == bfpm_pkg::FRM_RD_LAST)
        begin
          link.dev_sda_oe <= 1'b0;
          bit_q <= 5'h00;
        end
      end
    end
  end

  // Read answer handshake back into the link domain
  always_ff @(posedge link.scl or posedge rst)
  begin
    if (rst)
    begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
      link.dev_sda_o <= 1'b0;
    end
    else
    begin
      ack_meta_q <= rd_ack_q;
      ack_sync_q <= ack_meta_q;
    end
  end

  // ==========================================================
  // Synchronisers (clk_sys)
  logic [8:0] meta_q;
  logic [8:0] sync_q;
  logic [1:0] wr_meta_q;
  logic [1:0] rd_meta_q;
  logic wr_sync_q;
  logic rd_sync_q;
  logic wr_seen_q;
  logic rd_seen_q;
  logic en_s, input_low_lockout_s, warn_s, shut_s, cool_s, lim_s, b80_s, cyc_s, pgc_s;
  logic cyc_d_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 9'h000;
      sync_q <= 9'h000;
      wr_meta_q <= 2'h0;
      rd_meta_q <= 2'h0;
    end
    else
    begin
      meta_q <= {en_pin, input_low_lockout, temp_warn_cmp, temp_shut_cmp, temp_cool_cmp,
                 hs_limit_cmp, hs_below80_cmp, loop_cycle_tgl, pg_cmp};
      sync_q <= meta_q;
      wr_meta_q <= {wr_meta_q[0], wr_tgl_q};
      rd_meta_q <= {rd_meta_q[0], rd_tgl_q};
    end
  end
  assign {en_s, input_low_lockout_s, warn_s, shut_s, cool_s, lim_s, b80_s, cyc_s, pgc_s} = sync_q;
  assign wr_sync_q = wr_meta_q[1];
  assign rd_sync_q = rd_meta_q[1];

  // ==========================================================
  // Registers and fault state
  bfpm_pkg::bfpm_state_type state_q, state_d;
  logic [7:0] main_q, outc_q, vout_q, fault_w;
  logic [2:0] therm_cnt_q, hic_cnt_q;
  logic [3:0] ovl_cnt_q, pb_cnt_q;
  logic [CW-1:0] cool_q;
  logic [BW-1:0] blank_q;
  logic hs_block_q, ot_q, warn_q, pg_q, settled_q;
  logic enable, cyc_ev, run, wr_ev, restart_sel, pb_done, therm_trip, hic_trip, ovl_trip;

  assign wr_ev = wr_sync_q ^ wr_seen_q;
  assign cyc_ev = cyc_s ^ cyc_d_q;
  assign run = state_q == bfpm_pkg::ST_RUN;
  assign restart_sel = outc_q[bfpm_pkg::OC_RESTART_SEL];
  assign enable = en_s & ~input_low_lockout_s & ~main_q[bfpm_pkg::MC_SW_EN];
  assign pb_done = pb_cnt_q == bfpm_pkg::PREBIAS_CYC;
  assign therm_trip = !restart_sel || 3'(therm_cnt_q + 3'h1) == bfpm_pkg::THERM_LATCH_CNT;
  assign hic_trip = 3'(hic_cnt_q + 3'h1) == bfpm_pkg::HICCUP_LATCH_CNT;
  assign ovl_trip = cyc_ev && hs_block_q && ovl_cnt_q == bfpm_pkg::OVERLOAD_CYC;

  // Next fault state; disable always wins and clears a latch-off
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      bfpm_pkg::ST_OFF:
        if (enable) state_d = bfpm_pkg::ST_RUN;
      bfpm_pkg::ST_RUN:
        if (shut_s) state_d = therm_trip ? bfpm_pkg::ST_LATCH : bfpm_pkg::ST_THERM;
        else if (ovl_trip) state_d = hic_trip ? bfpm_pkg::ST_LATCH : bfpm_pkg::ST_HICCUP;
      bfpm_pkg::ST_THERM:
        if (cool_s && !shut_s) state_d = bfpm_pkg::ST_RUN;
      bfpm_pkg::ST_HICCUP:
        if (cool_q == '0) state_d = bfpm_pkg::ST_RUN;
      bfpm_pkg::ST_LATCH:
        state_d = bfpm_pkg::ST_LATCH;
    endcase
    if (!enable)
      state_d = bfpm_pkg::ST_OFF;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_q <= bfpm_pkg::ST_OFF;
    else
      state_q <= state_d;
  end

  // Register writes from the link; defaults only come back with power
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      main_q <= MAIN_RST;
      outc_q <= OUT_RST;
      vout_q <= VOUT_INIT;
      wr_seen_q <= 1'b0;
    end
    else
    begin
      wr_seen_q <= wr_sync_q;
      if (wr_ev && addr_q == bfpm_pkg::REG_MAIN_CTRL)
        main_q <= sh_q;
      if (wr_ev && addr_q == bfpm_pkg::REG_OUT_CTRL)
        outc_q <= sh_q;
      if (wr_ev && addr_q == bfpm_pkg::REG_VOUT)
        vout_q <= sh_q;
    end
  end

  // Read handshake: capture the addressed register for the link
  always_comb
  begin
    unique case (addr_q)
      bfpm_pkg::REG_MAIN_CTRL: fault_w = main_q;
      bfpm_pkg::REG_OUT_CTRL: fault_w = outc_q;
      bfpm_pkg::REG_VOUT: fault_w = vout_q;
      bfpm_pkg::REG_FAULT:
        fault_w = {warn_q, enable, 1'b0, settled_q, state_q == bfpm_pkg::ST_HICCUP |
                   (state_q == bfpm_pkg::ST_THERM & restart_sel), ot_q,
                   state_q == bfpm_pkg::ST_LATCH, pg_q};
      default: fault_w = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_seen_q <= 1'b0;
      rd_ack_q <= 1'b0;
      rd_word_q <= 8'h00;
    end
    else if (rd_sync_q != rd_seen_q)
    begin
      rd_seen_q <= rd_sync_q;
      rd_word_q <= fault_w;
      rd_ack_q <= rd_sync_q;
    end
  end

  // Consecutive fault counters, cleared once power-good is reached
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      therm_cnt_q <= 3'h0;
      hic_cnt_q <= 3'h0;
    end
    else if (!enable)
    begin
      therm_cnt_q <= 3'h0;
      hic_cnt_q <= 3'h0;
    end
    // A fault hit while still in regulation must count as the first of a run
    else if (run && shut_s)
      therm_cnt_q <= 3'(therm_cnt_q + 3'h1);
    else if (run && ovl_trip)
      hic_cnt_q <= 3'(hic_cnt_q + 3'h1);
    else if (run && pg_q)
    begin
      therm_cnt_q <= 3'h0;
      hic_cnt_q <= 3'h0;
    end
  end

  // Cycle-by-cycle limit and overload/start-up cycle counting
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cyc_d_q <= 1'b0;
      hs_block_q <= 1'b0;
      ovl_cnt_q <= 4'h0;
      pb_cnt_q <= 4'h0;
    end
    else
    begin
      cyc_d_q <= cyc_s;
      if (!run)
      begin
        hs_block_q <= 1'b0;
        ovl_cnt_q <= 4'h0;
        pb_cnt_q <= 4'h0;
      end
      else
      begin
        if (lim_s)
          hs_block_q <= 1'b1;
        else if (b80_s)
          hs_block_q <= 1'b0;
        if (cyc_ev)
          ovl_cnt_q <= hs_block_q ? 4'(ovl_cnt_q + 4'h1) : 4'h0;
        if (cyc_ev && !pb_done)
          pb_cnt_q <= 4'(pb_cnt_q + 4'h1);
      end
    end
  end

  // Hiccup cool-off and power-good blanking timers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cool_q <= '0;
      blank_q <= '0;
    end
    else
    begin
      if (state_d == bfpm_pkg::ST_HICCUP && state_q != bfpm_pkg::ST_HICCUP)
        cool_q <= CW'(COOL_CYC - 1);
      else if (cool_q != '0)
        cool_q <= cool_q - CW'(1);
      if (run && wr_ev && addr_q == bfpm_pkg::REG_VOUT && sh_q < vout_q)
        blank_q <= BW'(BLANK_CYC);
      else if (blank_q != '0)
        blank_q <= blank_q - BW'(1);
    end
  end

  // Status flags; a hardware set beats a host clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ot_q <= 1'b0;
      warn_q <= 1'b0;
      pg_q <= 1'b0;
      settled_q <= 1'b0;
    end
    else
    begin
      warn_q <= warn_s & ~shut_s & (state_q != bfpm_pkg::ST_THERM);
      if (run && shut_s)
        ot_q <= 1'b1;
      else if (wr_ev && addr_q == bfpm_pkg::REG_FAULT && !sh_q[bfpm_pkg::FLT_OT])
        ot_q <= 1'b0;
      if (!run)
        pg_q <= 1'b0;
      else if (blank_q == '0)
        pg_q <= pgc_s;
      if (run && pg_q)
        settled_q <= 1'b1;
      else if (!run)
        settled_q <= 1'b0;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      switches_off <= 1'b1;
      hs_gate_allow <= 1'b0;
      ls_force_on <= 1'b0;
      neg_limit_en <= 1'b0;
      forced_fixed_switching <= 1'b0;
      pg_pin_o <= 1'b0;
      pg_pin_oe <= 1'b1;
    end
    else
    begin
      switches_off <= !run;
      hs_gate_allow <= run & ~hs_block_q;
      ls_force_on <= run & hs_block_q;
      neg_limit_en <= run & pb_done;
      forced_fixed_switching <= run & ((outc_q[bfpm_pkg::OC_FORCED] & pb_done) |
                                       (blank_q != '0));
      pg_pin_oe <= ~pg_q;
    end
  end

  assign output_discharge_enable = outc_q[bfpm_pkg::OC_DISCHARGE];
  assign full_duty_disable = outc_q[bfpm_pkg::OC_FULL_DUTY];
  assign ramp_rate = outc_q[bfpm_pkg::OC_RAMP_MSB:0];
  assign high_side_current_limit_sel = main_q[bfpm_pkg::MC_HIGH_SIDE_CURRENT_LIMIT_SEL_MSB:bfpm_pkg::MC_HIGH_SIDE_CURRENT_LIMIT_SEL_LSB];
  assign on_time_select = main_q[bfpm_pkg::MC_TON_MSB:bfpm_pkg::MC_TON_LSB];
  assign vout_code = vout_q;
endmodule

`default_nettype wire

// ==== logic/bfpm_host.sv ====
/*
  Host end of the two-wire link: makes the link clock from clk_sys by a
  divider and runs one register write or read per command.
  Assumes the regulator samples data on the rising link clock edge.
*/
`timescale 1ns/1ns
`default_nettype none

module bfpm_host #(
  parameter int DIV_HALF = bfpm_pkg::LINK_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  bfpm_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [5:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  localparam int DW = $clog2(DIV_HALF + 1);

  bfpm_pkg::bfpm_host_state_type state_q;
  logic [DW-1:0] div_q;
  logic [4:0] bit_q;
  logic [19:0] frame_q;
  logic rd_q;
  logic [7:0] data_q;
  logic sda_meta_q;
  logic sda_sync_q;

  // ==========================================================
  // Data line synchroniser
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
    end
    else
    begin
      sda_meta_q <= link.sda;
      sda_sync_q <= sda_meta_q;
    end
  end

  // ==========================================================
  // Frame engine: low half sets data, high half lets the device sample
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= bfpm_pkg::HS_IDLE;
      div_q <= '0;
      bit_q <= 5'h00;
      frame_q <= 20'hfffff;
      rd_q <= 1'b0;
      data_q <= 8'h00;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      link.scl <= 1'b1;
      link.host_sda_o <= 1'b0;
      link.host_sda_oe <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      unique case (state_q)
        bfpm_pkg::HS_IDLE:
          if (cmd_valid)
          begin
            // Read frames release data after the address for the turnaround
            frame_q <= {1'b0, cmd_read, cmd_addr, cmd_read ? 12'hfff : {cmd_wdata, 4'hf}};
            rd_q <= cmd_read;
            bit_q <= 5'h00;
            div_q <= '0;
            cmd_ready <= 1'b0;
            link.scl <= 1'b0;
            link.host_sda_oe <= 1'b1;
            state_q <= bfpm_pkg::HS_LOW;
          end
        bfpm_pkg::HS_LOW:
          if (div_q == DW'(DIV_HALF - 1))
          begin
            div_q <= '0;
            link.scl <= 1'b1;
            state_q <= bfpm_pkg::HS_HIGH;
            if (rd_q && bit_q >= bfpm_pkg::FRM_RD_FIRST)
              data_q <= {data_q[6:0], sda_sync_q};
          end
          else
            div_q <= div_q + DW'(1);
        bfpm_pkg::HS_HIGH:
          if (div_q != DW'(DIV_HALF - 1))
            div_q <= div_q + DW'(1);
          else if (bit_q == (rd_q ? bfpm_pkg::FRM_RD_LAST : bfpm_pkg::FRM_WR_LAST))
          begin
            // Clock parks high so the device sees no edge between frames
            link.host_sda_oe <= 1'b0;
            cmd_ready <= 1'b1;
            rsp_valid <= rd_q;
            rsp_data <= data_q;
            state_q <= bfpm_pkg::HS_IDLE;
          end
          else
          begin
            div_q <= '0;
            bit_q <= bit_q + 5'h01;
            frame_q <= {frame_q[18:0], 1'b1};
            link.host_sda_oe <= ~frame_q[18];
            link.scl <= 1'b0;
            state_q <= bfpm_pkg::HS_LOW;
          end
        default:
          state_q <= bfpm_pkg::HS_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== test/bfpm_assertions.sv ====
/*
  Checker on the link wires and the regulator's fault pins.
  Assumes the bench hands over the interface signals and device pins by name.
*/
`timescale 1ns/1ns
`default_nettype none

module bfpm_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic en_pin,
  input wire logic input_low_lockout,
  input wire logic temp_shut_cmp,
  input wire logic hs_limit_cmp,
  input wire logic switches_off,
  input wire logic hs_gate_allow,
  input wire logic neg_limit_en,
  input wire logic pg_pin_oe
);
  // ==========================================================
  // Everything here runs on the system clock; windows allow for input sync
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  shut_off_a: assert property (temp_shut_cmp [*4] |-> ##[0:3] switches_off)
    else $error("switches left on above shutdown temperature");
  fault_pg_a: assert property ($rose(switches_off) |-> ##[0:2] pg_pin_oe)
    else $error("power-good released while switches forced off");
  hs_cut_a: assert property (hs_limit_cmp [*3] |-> ##[0:2] !hs_gate_allow)
    else $error("high side allowed while limit is hit");
  neg_clear_a: assert property (!en_pin [*4] |-> ##[0:3] !neg_limit_en)
    else $error("negative limit kept while disabled");
  enable_off_a: assert property (!en_pin [*4] |-> ##[0:3] (switches_off && pg_pin_oe))
    else $error("output active while enable pin low");
  lockout_off_a: assert property (input_low_lockout [*4] |-> ##[0:3] !neg_limit_en)
    else $error("negative limit kept under input lockout");
  no_contend_a: assert property (!(host_sda_oe && dev_sda_oe))
    else $error("both ends pull the data line");
  neg_run_a: assert property ($rose(neg_limit_en) |-> !switches_off)
    else $error("negative limit raised while switches off");

  // Main scenarios reached
  cover property ($fell(scl));
  cover property ($rose(dev_sda_oe));
  cover property ($rose(neg_limit_en));
endmodule

`default_nettype wire

// ==== test/testbench.sv ====
/*
  Bench joining host and regulator ends on the link; registers are compared
  with a small model, fault status with fixed expected flags. Assumes package and interface exist.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic clk_sys, rst, cmd_valid, cmd_read, cmd_ready, rsp_valid;
  logic [5:0] cmd_addr;
  logic [7:0] cmd_wdata, rsp_data, vout_code;
  logic en_pin, input_low_lockout, temp_warn_cmp, temp_shut_cmp, temp_cool_cmp;
  logic hs_limit_cmp, hs_below80_cmp, loop_cycle_tgl, pg_cmp;
  logic switches_off, hs_gate_allow, neg_limit_en, pg_pin_oe, ls_force_on;
  logic [1:0] on_time_select, high_side_current_limit_sel;
  logic [3:0] ramp_rate;
  logic [31:0] seed = 32'h2a0d;
  logic [7:0] d;
  int num_errors, checks_done;
  int model[3];

  // ==========================================================
  // Ends, link and checker
  bfpm_link_if lnk();
  bfpm_host bfpm_host_i (.clk_sys, .rst, .link(lnk), .cmd_valid, .cmd_read, .cmd_addr,
    .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data);
  bfpm_device #(.COOL_CYC(400), .BLANK_CYC(20)) bfpm_device_i (.clk_sys, .rst, .link(lnk),
    .en_pin, .input_low_lockout, .temp_warn_cmp, .temp_shut_cmp, .temp_cool_cmp,
    .hs_limit_cmp, .hs_below80_cmp, .loop_cycle_tgl, .pg_cmp, .switches_off, .hs_gate_allow,
    .ls_force_on, .neg_limit_en, .forced_fixed_switching(), .output_discharge_enable(),
    .full_duty_disable(), .high_side_current_limit_sel, .on_time_select, .ramp_rate,
    .vout_code, .pg_pin_o(), .pg_pin_oe);
  bfpm_checker bfpm_checker_i (.clk_sys, .rst, .scl(lnk.scl), .host_sda_oe(lnk.host_sda_oe),
    .dev_sda_oe(lnk.dev_sda_oe), .en_pin, .input_low_lockout, .temp_shut_cmp, .hs_limit_cmp,
    .switches_off, .hs_gate_allow, .neg_limit_en, .pg_pin_oe);

  // ==========================================================
  // Clock, helpers
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Status byte from flags, top bit first; config error always reads 0
  function automatic logic [7:0] fs(input logic w, e, s, r, o, l, i);
    return {w, e, 1'b0, s, r, o, l, i};
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      num_errors++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One command; the request is held until the edge that takes it
  task automatic xfer(input logic r, input logic [5:0] a, input logic [7:0] w);
    int n;
    cmd_read = r;
    cmd_addr = a;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++)
      tick(1);
    if (n == 200)
    begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] w);
    xfer(1'b0, a, w);
    if (a < 6'h03)
      model[a] = w;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    check({7'h00, rsp_valid}, 8'h01);
    check(rsp_data, e);
  endtask

  task automatic tog(input int n);
    repeat (n)
    begin
      loop_cycle_tgl = ~loop_cycle_tgl;
      tick(4);
    end
  endtask

  // Shutdown then cool-down of the die
  task automatic heat();
    {temp_shut_cmp, temp_cool_cmp} = 2'b10;
    tick(10);
    {temp_shut_cmp, temp_cool_cmp} = 2'b01;
    tick(10);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {cmd_valid, cmd_read, cmd_addr, cmd_wdata, input_low_lockout, temp_warn_cmp} = '0;
    {temp_shut_cmp, hs_limit_cmp, loop_cycle_tgl, pg_cmp} = '0;
    {en_pin, temp_cool_cmp, hs_below80_cmp} = 3'h7;
    num_errors = 0;
    checks_done = 0;
    model = '{bfpm_pkg::MAIN_CTRL_RST, bfpm_pkg::OUT_CTRL_RST, bfpm_pkg::VOUT_RST};
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    for (int a = 0; a < 3; a++)
      rd(a[5:0], model[a][7:0]);
    rd(6'h3f, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      d = 8'(rnd());
      d[0] = d[0] & (k % 3 != 0);
      d[5] = d[5] | (k % 3 == 1);
      wr(6'(k % 3), d);
      rd(6'(k % 3), model[k % 3][7:0]);
      check(vout_code, model[2][7:0]);
    end
    check({on_time_select, high_side_current_limit_sel, ramp_rate},
      {model[0][7:4], model[1][3:0]});
    $display("end of register test");
    pg_cmp = 1'b1;
    tog(7);
    check({7'h00, neg_limit_en}, 8'h00);
    tog(1);
    check({7'h00, neg_limit_en}, 8'h01);
    temp_warn_cmp = 1'b1;
    rd(6'h03, fs(1, 1, 1, 0, 0, 0, 1));
    {temp_shut_cmp, temp_cool_cmp} = 2'b10;
    tick(10);
    check({6'h00, switches_off, pg_pin_oe}, 8'h03);
    rd(6'h03, fs(0, 1, 0, 1, 1, 0, 0));
    {temp_shut_cmp, temp_cool_cmp, temp_warn_cmp} = 3'b010;
    tick(10);
    rd(6'h03, fs(0, 1, 1, 0, 1, 0, 1));
    wr(6'h03, 8'h00);
    rd(6'h03, fs(0, 1, 1, 0, 0, 0, 1));
    $display("end of thermal test");
    wr(6'h01, 8'h00);
    heat();
    rd(6'h03, fs(0, 1, 0, 0, 1, 1, 0));
    wr(6'h00, 8'h01);
    wr(6'h00, 8'h00);
    tick(10);
    rd(6'h03, fs(0, 1, 1, 0, 1, 0, 1));
    wr(6'h01, 8'h20);
    wr(6'h03, 8'h00);
    pg_cmp = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      heat();
      if (i == 2)
        rd(6'h03, fs(0, 1, 0, 0, 1, 0, 0));
    end
    rd(6'h03, fs(0, 1, 0, 0, 1, 1, 0));
    en_pin = 1'b0;
    tick(10);
    {en_pin, pg_cmp} = 2'b11;
    tick(10);
    rd(6'h03, fs(0, 1, 1, 0, 1, 0, 1));
    rd(6'h01, model[1][7:0]);
    $display("end of latch-off test");
    wr(6'h03, 8'h00);
    hs_limit_cmp = 1'b1;
    tick(4);
    check({6'h00, ls_force_on, hs_gate_allow}, 8'h02);
    tog(8);
    rd(6'h03, fs(0, 1, 0, 1, 0, 0, 0));
    check({7'h00, switches_off}, 8'h01);
    hs_limit_cmp = 1'b0;
    tick(400);
    rd(6'h03, fs(0, 1, 1, 0, 0, 0, 1));
    input_low_lockout = 1'b1;
    tick(10);
    check({7'h00, switches_off}, 8'h01);
    input_low_lockout = 1'b0;
    $display("end of overload test");
    stop_test();
  end
endmodule

`default_nettype wire
